// >>> bench/ict_cycle_timing_bench.sv
`timescale 1ns/1ps

module ict_cycle_timing_bench import ict_pkg::*; ;
    localparam ict_mode_e DR = MODE_DATA_REGISTER_OPERAND;
    localparam ict_mode_e IN = MODE_INDIRECT;
    localparam ict_mode_e IX = MODE_INDEXED;
    localparam ict_mode_e PX = MODE_PC_INDEXED;
    localparam ict_mode_e AL = MODE_ABS_LONG;
    localparam ict_mode_e IM = MODE_IMMEDIATE;
    localparam ict_form_e FD = FORM_TO_DATA_REG;
    localparam ict_form_e FA = FORM_TO_ADDR_REG;
    localparam ict_form_e FM = FORM_TO_MEMORY;

    logic               mclk;
    logic               rst;
    logic               req_valid;
    logic               req_ready;
    logic               res_valid;
    logic               slow;
    ict_req_s           req;
    ict_res_s           res;
    logic [WAIT_W-1:0]  wait_per;
    int                 n_fail;
    int                 compares;

    ict_cycle_timing i_ict_cycle_timing (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .res_valid(res_valid), .res(res));
    ict_mem_model i_ict_mem_model (.slow(slow), .wait_per_cycle(wait_per));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [CLK_W-1:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // One request, answered one cycle later; wait total follows the bus cycle count
    task automatic run(input ict_op_e o, input ict_size_e s, input ict_form_e f,
                       input ict_mode_e sm, dm, input logic [15:0] d,
                       input logic [CLK_W-1:0] c, input logic [CNT_W-1:0] rd, wr,
                       input logic ill);
        logic [WAIT_W-1:0] w;
        // Read the wait rate only after a change of memory speed has settled
        @(posedge mclk);
        w = WAIT_W'(wait_per * (rd + wr));
        req <= '{op:o, size:s, form:f, src_mode:sm, dst_mode:dm, src_data:d, wait_clocks:w};
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        #1;
        chk("res_valid", 1, res_valid);
        chk("clocks", c + CLK_W'(w), res.clocks);
        chk("reads", rd, res.reads);
        chk("writes", wr, res.writes);
        chk("illegal", ill, res.illegal);
        if (!ill) chk("bus_floor", 1, res.clocks >= 4 * (res.reads + res.writes));
        @(posedge mclk);
        #1;
        chk("res_pulse", 0, res_valid);
    endtask

    task automatic t_move;
        run(OP_MOVE, SIZE_BYTE, FD, DR, DR, 0, 4, 1, 0, 0);
        run(OP_MOVE, SIZE_BYTE, FD, AL, AL, 0, 28, 6, 1, 0);
        run(OP_MOVE, SIZE_LONG, FD, DR, IN, 0, 12, 1, 2, 0);
        run(OP_MOVE, SIZE_LONG, FD, AL, AL, 0, 36, 7, 2, 0);
        run(OP_MOVE, SIZE_BYTE, FD, IX, DR, 0, 14, 3, 0, 0);
        run(OP_MOVE, SIZE_LONG, FD, PX, AL, 0, 34, 6, 2, 0);
    endtask

    task automatic t_std;
        run(OP_ADD, SIZE_BYTE, FD, DR, DR, 0, 4, 1, 0, 0);
        run(OP_ADD, SIZE_WORD, FM, DR, IN, 0, 12, 2, 1, 0);
        run(OP_SUB, SIZE_LONG, FM, DR, AL, 0, 28, 5, 2, 0);
        run(OP_ADD, SIZE_WORD, FA, DR, DR, 0, 8, 1, 0, 0);
        run(OP_SUB, SIZE_BYTE, FA, DR, DR, 0, 0, 0, 0, 1);
        run(OP_AND, SIZE_LONG, FD, DR, DR, 0, 8, 1, 0, 0);
        run(OP_ADD, SIZE_LONG, FD, DR, DR, 0, 8, 1, 0, 0);
        run(OP_OR, SIZE_LONG, FD, IN, DR, 0, 14, 3, 0, 0);
        run(OP_ADD, SIZE_LONG, FD, IM, DR, 0, 16, 3, 0, 0);
    endtask

    task automatic t_xor_cmp;
        run(EXCLUSIVE_OR_OP, SIZE_WORD, FD, DR, DR, 0, 4, 1, 0, 0);
        run(EXCLUSIVE_OR_OP, SIZE_LONG, FD, DR, DR, 0, 8, 1, 0, 0);
        run(EXCLUSIVE_OR_OP, SIZE_WORD, FD, IN, DR, 0, 0, 0, 0, 1);
        run(EXCLUSIVE_OR_OP, SIZE_LONG, FM, DR, IN, 0, 20, 3, 2, 0);
        run(COMPARE_OP, SIZE_WORD, FA, DR, DR, 0, 6, 1, 0, 0);
        run(COMPARE_OP, SIZE_BYTE, FD, DR, DR, 0, 4, 1, 0, 0);
        run(COMPARE_OP, SIZE_LONG, FD, DR, DR, 0, 6, 1, 0, 0);
        run(COMPARE_OP, SIZE_WORD, FM, DR, IN, 0, 0, 0, 0, 1);
    endtask

    task automatic t_muldiv;
        run(SIGNED_DIVIDE, SIZE_WORD, FD, DR, DR, 0, 158, 1, 0, 0);
        run(UNSIGNED_DIVIDE, SIZE_WORD, FD, DR, DR, 0, 140, 1, 0, 0);
        run(UNSIGNED_DIVIDE, SIZE_WORD, FD, IN, DR, 0, 144, 2, 0, 0);
        run(UNSIGNED_MULTIPLY, SIZE_WORD, FD, DR, DR, 16'hffff, 70, 1, 0, 0);
        run(UNSIGNED_MULTIPLY, SIZE_WORD, FD, DR, DR, 16'h00ff, 54, 1, 0, 0);
        run(SIGNED_MULTIPLY, SIZE_WORD, FD, DR, DR, 16'h5555, 70, 1, 0, 0);
        run(SIGNED_MULTIPLY, SIZE_WORD, FD, DR, DR, 16'hffff, 40, 1, 0, 0);
        run(SIGNED_MULTIPLY, SIZE_WORD, FD, DR, DR, 16'h0000, 38, 1, 0, 0);
    endtask

    // Slow memory: every bus cycle of the instruction gains the same wait
    task automatic t_wait;
        slow <= 1'b1;
        run(OP_MOVE, SIZE_LONG, FD, AL, AL, 0, 36, 7, 2, 0);
        run(OP_ADD, SIZE_WORD, FM, DR, IN, 0, 12, 2, 1, 0);
        slow <= 1'b0;
    endtask

    initial begin
        n_fail = 0;
        compares = 0;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        repeat (10) @(posedge mclk);
        chk("res_valid_rst", 0, res_valid);
        chk("res_rst", 0, CLK_W'(res.clocks));
        rst <= 1'b0;
        t_move();
        t_std();
        t_xor_cmp();
        t_muldiv();
        t_wait();
        final_report();
    end

    initial begin
        repeat (400) @(posedge mclk);
        n_fail++;
        final_report();
    end
endmodule // ict_cycle_timing_bench

// >>> bench/ict_mem_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Memory on the system bus: prompt or slow, in wait clocks per cycle
// ****************************************************************
module ict_mem_model import ict_pkg::*; #(
    parameter int SLOW_WAITS = 2
) (
    input  wire logic               slow,
    output logic [WAIT_W-1:0]       wait_per_cycle
);
    // Slow memory stretches every read and write cycle alike
    assign wait_per_cycle = slow ? WAIT_W'(SLOW_WAITS) : '0;
endmodule // ict_mem_model

// >>> rtl/ict_addr_calc.sv
`timescale 1ns/1ps

module ict_addr_calc import ict_pkg::*; #(
    parameter int CW = AC_CW
) (
    input  wire ict_mode_e          mode,
    input  wire logic               long_size,
    input  wire logic               for_write,
    output logic [CW-1:0]           clocks,
    output logic [AC_RW-1:0]        reads,
    output logic                    is_memory,
    output logic                    known
);

    logic [CW-1:0]    clk_bw;
    logic [AC_RW-1:0] rd_bw;

    // Only read cycles are ever produced here; there is no write output.
    // Indexed modes have no input for index width: cost is the same.
    always_comb begin
        clk_bw    = '0;
        rd_bw     = '0;
        is_memory = 1'b1;
        known     = 1'b1;
        case (mode)
            MODE_DATA_REGISTER_OPERAND,
            MODE_ADDRESS_REGISTER_OPERAND: is_memory = 1'b0;
            MODE_INDIRECT:        begin clk_bw = AC_CLK_IND;     rd_bw = AC_RD_ONE;   end
            MODE_POSTINC:         begin clk_bw = AC_CLK_POSTINC; rd_bw = AC_RD_ONE;   end
            MODE_PREDEC: begin
                // A written destination needs no extra decrement time
                clk_bw = for_write ? AC_CLK_IND : AC_CLK_PREDEC;
                rd_bw  = AC_RD_ONE;
            end
            MODE_DISPLACEMENT:    begin clk_bw = AC_CLK_DISP;    rd_bw = AC_RD_TWO;   end
            MODE_INDEXED:         begin clk_bw = AC_CLK_INDEXED; rd_bw = AC_RD_TWO;   end
            MODE_ABS_SHORT:       begin clk_bw = AC_CLK_ABSW;    rd_bw = AC_RD_TWO;   end
            MODE_ABS_LONG:        begin clk_bw = AC_CLK_ABSL;    rd_bw = AC_RD_THREE; end
            MODE_PC_DISPLACEMENT: begin clk_bw = AC_CLK_PCDISP;  rd_bw = AC_RD_TWO;   end
            MODE_PC_INDEXED:      begin clk_bw = AC_CLK_PCINDEX; rd_bw = AC_RD_TWO;   end
            MODE_IMMEDIATE:       begin clk_bw = AC_CLK_IMM;     rd_bw = AC_RD_ONE;   end
            default: begin
                is_memory = 1'b0;
                known     = 1'b0;
            end
        endcase
    end

    // A long memory operand costs one more bus read of four clocks
    always_comb begin
        if (long_size && is_memory) begin
            clocks = CW'(clk_bw + AC_LONG_CLK);
            reads  = AC_RW'(rd_bw + AC_LONG_RD);
        end else begin
            clocks = clk_bw;
            reads  = rd_bw;
        end
    end

endmodule // ict_addr_calc

// >>> rtl/ict_cycle_timing.sv
`timescale 1ns/1ps


module ict_cycle_timing import ict_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       req_valid,
    input  wire ict_req_s   req,
    output logic            req_ready,
    output logic            res_valid,
    output ict_res_s        res
);

    // ****************************************************************
    // Address calculation for source and destination
    // ****************************************************************
    logic              is_move;
    logic              is_long;
    logic              word_src_op;
    logic [AC_CW-1:0]  src_clk;
    logic [AC_RW-1:0]  src_rd;
    logic              src_mem;
    logic              src_known;
    logic [AC_CW-1:0]  dst_clk;
    logic [AC_RW-1:0]  dst_rd;
    logic              dst_mem;
    logic              dst_known;

    assign is_move     = (req.op == OP_MOVE);
    assign is_long     = (req.size == SIZE_LONG);
    // Divide and multiply always take a 16-bit source operand
    assign word_src_op = (req.op == SIGNED_DIVIDE) || (req.op == UNSIGNED_DIVIDE) ||
                         (req.op == SIGNED_MULTIPLY) || (req.op == UNSIGNED_MULTIPLY);

    ict_addr_calc #(
        .CW        (AC_CW)
    ) u_src_calc (
        .mode      (req.src_mode),
        .long_size (is_long && !word_src_op),
        .for_write (1'b0),
        .clocks    (src_clk),
        .reads     (src_rd),
        .is_memory (src_mem),
        .known     (src_known)
    );

    // A move destination is costed at byte size; long adds its second write later
    ict_addr_calc #(
        .CW        (AC_CW)
    ) u_dst_calc (
        .mode      (req.dst_mode),
        .long_size (is_long && !is_move),
        .for_write (is_move),
        .clocks    (dst_clk),
        .reads     (dst_rd),
        .is_memory (dst_mem),
        .known     (dst_known)
    );

    // ****************************************************************
    // Data dependent multiply count
    // ****************************************************************
    function automatic logic [4:0] ones16(input logic [DATA_W-1:0] v);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < DATA_W; i++) begin
            c = c + {4'h0, v[i]};
        end
        return c;
    endfunction

    logic [4:0]       mul_n;
    logic [CLK_W-1:0] mul_clk;

    always_comb begin
        if (req.op == SIGNED_MULTIPLY) begin
            // Zero appended below bit 0; each differing neighbour pair counts
            mul_n = ones16(req.src_data ^ {req.src_data[DATA_W-2:0], 1'b0});
        end else begin
            mul_n = ones16(req.src_data);
        end
        mul_clk = CLK_W'(MUL_BASE_CLK + CLK_W'({mul_n, 1'b0}));
    end

    // ****************************************************************
    // Cost selection
    // ****************************************************************
    logic             dst_writable;
    logic             src_reg_or_imm;
    logic [CLK_W-1:0] long_base;
    logic [CLK_W-1:0] base_clk;
    logic [CNT_W-1:0] base_rd;
    logic [CNT_W-1:0] base_wr;
    logic [CLK_W-1:0] add_clk;
    logic [CNT_W-1:0] add_rd;
    logic             bad;
    ict_res_s         res_next;

    assign dst_writable   = dst_mem && (req.dst_mode != MODE_PC_DISPLACEMENT) &&
                            (req.dst_mode != MODE_PC_INDEXED) &&
                            (req.dst_mode != MODE_IMMEDIATE);
    assign src_reg_or_imm = !src_mem || (req.src_mode == MODE_IMMEDIATE);
    assign long_base      = src_reg_or_imm ? STD_REG_LONG_RI : STD_REG_LONG_CLK;

    always_comb begin
        base_clk = '0;
        base_rd  = BASE_RD;
        base_wr  = '0;
        add_clk  = CLK_W'(src_clk);
        add_rd   = CNT_W'(src_rd);
        bad      = !src_known;
        case (req.op)
            OP_MOVE: begin
                // Fetch plus source reads plus destination extension reads and stores, nothing else
                base_clk = MOVE_BASE_CLK;
                bad      = !src_known || !dst_known ||
                           (dst_mem && !dst_writable);
                if (dst_mem) begin
                    add_clk = CLK_W'(CLK_W'(src_clk) + CLK_W'(dst_clk) +
                                     (is_long ? MOVE_LONG_DST_CLK : '0));
                    add_rd  = CNT_W'(CNT_W'(src_rd) + CNT_W'(dst_rd) - 4'h1);
                    base_wr = is_long ? WR_LONG : WR_BYTE_WORD;
                end
            end
            OP_ADD, OP_SUB, OP_AND, OP_OR: begin
                case (req.form)
                    FORM_TO_DATA_REG: begin
                        base_clk = is_long ? long_base : STD_REG_BW_CLK;
                    end
                    FORM_TO_ADDR_REG: begin
                        // Logic ops have no address register form at all
                        bad      = bad || (req.size == SIZE_BYTE) ||
                                   (req.op == OP_AND) || (req.op == OP_OR);
                        base_clk = is_long ? long_base : ADD_AREG_BW_CLK;
                    end
                    FORM_TO_MEMORY: begin
                        base_clk = is_long ? STD_MEM_LONG_CLK : STD_MEM_BW_CLK;
                        base_wr  = is_long ? WR_LONG : WR_BYTE_WORD;
                        add_clk  = CLK_W'(dst_clk);
                        add_rd   = CNT_W'(dst_rd);
                        bad      = !dst_writable;
                    end
                    default: bad = 1'b1;
                endcase
            end
            COMPARE_OP: begin
                case (req.form)
                    FORM_TO_DATA_REG: base_clk = is_long ? CMP_LONG_CLK : STD_REG_BW_CLK;
                    FORM_TO_ADDR_REG: begin
                        bad      = bad || (req.size == SIZE_BYTE);
                        base_clk = CMP_AREG_CLK;
                    end
                    default: bad = 1'b1;
                endcase
            end
            EXCLUSIVE_OR_OP: begin
                case (req.form)
                    FORM_TO_DATA_REG: begin
                        bad      = (req.src_mode != MODE_DATA_REGISTER_OPERAND);
                        base_clk = is_long ? XOR_REG_LONG_CLK : STD_REG_BW_CLK;
                        add_clk  = '0;
                        add_rd   = '0;
                    end
                    FORM_TO_MEMORY: begin
                        base_clk = is_long ? STD_MEM_LONG_CLK : STD_MEM_BW_CLK;
                        base_wr  = is_long ? WR_LONG : WR_BYTE_WORD;
                        add_clk  = CLK_W'(dst_clk);
                        add_rd   = CNT_W'(dst_rd);
                        bad      = !dst_writable;
                    end
                    default: bad = 1'b1;
                endcase
            end
            SIGNED_DIVIDE, UNSIGNED_DIVIDE: begin
                // Worst case only; the best case lies within ten percent of it
                base_clk = (req.op == SIGNED_DIVIDE) ? SDIV_MAX_CLK : UDIV_MAX_CLK;
                bad      = bad || (req.form != FORM_TO_DATA_REG);
            end
            SIGNED_MULTIPLY, UNSIGNED_MULTIPLY: begin
                base_clk = mul_clk;
                bad      = bad || (req.form != FORM_TO_DATA_REG);
            end
            default: bad = 1'b1;
        endcase
    end

    // Wait states stretch the total; the bus cycle count is unchanged
    always_comb begin
        res_next.illegal = bad;
        if (bad) begin
            res_next.clocks = '0;
            res_next.reads  = '0;
            res_next.writes = '0;
        end else begin
            res_next.clocks = CLK_W'(base_clk + add_clk + CLK_W'(req.wait_clocks));
            res_next.reads  = CNT_W'(base_rd + add_rd);
            res_next.writes = base_wr;
        end
    end

    // ****************************************************************
    // Result register
    // ****************************************************************
    // Combinational lookup with a single registered stage: always ready
    assign req_ready = 1'b1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= req_valid;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            res <= '0;
        end else if (req_valid) begin
            res <= res_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_resp_latency: assert property (@(posedge mclk) disable iff (rst)
        req_valid |=> res_valid)
        else $error("result did not follow request");

    a_bus_floor: assert property (@(posedge mclk) disable iff (rst)
        (res_valid && !res.illegal) |->
        (res.clocks >= CLK_W'(BUS_CYCLE_CLK * (res.reads + res.writes))))
        else $error("clock count below bus cycle floor");

    a_wait_added: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && !bad) |=>
        (res.clocks >= CLK_W'($past(req.wait_clocks)) +
                       CLK_W'(BUS_CYCLE_CLK * (res.reads + res.writes))))
        else $error("wait states not added");

    a_move_byte_ends: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && is_move && req.size == SIZE_BYTE && req.wait_clocks == '0 &&
         req.src_mode == MODE_ABS_LONG && req.dst_mode == MODE_ABS_LONG) |=>
        (res.clocks == MOVE_BYTE_WORST_CLK && res.reads == MOVE_BYTE_WORST_RD &&
         res.writes == WR_BYTE_WORD))
        else $error("byte move worst case wrong");

    a_move_long_mem: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && is_move && is_long && req.wait_clocks == '0 &&
         req.src_mode == MODE_DATA_REGISTER_OPERAND && req.dst_mode == MODE_INDIRECT) |=>
        (res.clocks == MOVE_REG_IND_L_CLK && res.reads == BASE_RD && res.writes == WR_LONG))
        else $error("long move to indirect wrong");

    a_move_long_worst: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && is_move && is_long && req.wait_clocks == '0 &&
         req.src_mode == MODE_ABS_LONG && req.dst_mode == MODE_ABS_LONG) |=>
        (res.clocks == MOVE_LONG_WORST_CLK && res.reads == MOVE_LONG_WORST_RD))
        else $error("long move worst case wrong");

    a_no_reg_writes: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && !is_move && req.form != FORM_TO_MEMORY) |=> (res.writes == '0))
        else $error("write cycle without memory destination");

    a_areg_no_byte: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && !is_move && req.form == FORM_TO_ADDR_REG && req.size == SIZE_BYTE)
        |=> res.illegal)
        else $error("byte to address register accepted");

    a_xor_src_only: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && req.op == EXCLUSIVE_OR_OP && req.form == FORM_TO_DATA_REG &&
         req.src_mode != MODE_DATA_REGISTER_OPERAND) |=> res.illegal)
        else $error("exclusive-or source not refused");

    a_cmp_no_mem: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && req.op == COMPARE_OP && req.form == FORM_TO_MEMORY) |=> res.illegal)
        else $error("compare to memory accepted");

    a_div_bound: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && req.op == UNSIGNED_DIVIDE && !bad && req.wait_clocks == '0 &&
         !src_mem) |=> (res.clocks == UDIV_MAX_CLK))
        else $error("unsigned divide time wrong");

    a_mul_range: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && word_src_op && req.op != SIGNED_DIVIDE && req.op != UNSIGNED_DIVIDE &&
         !bad && req.wait_clocks == '0 && !src_mem) |=>
        (res.clocks >= MUL_BASE_CLK && res.clocks <= MUL_MAX_CLK && !res.clocks[0]))
        else $error("multiply time out of range");

    a_long_reg_base: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && req.op == OP_ADD && is_long && req.form == FORM_TO_DATA_REG &&
         req.src_mode == MODE_DATA_REGISTER_OPERAND && req.wait_clocks == '0) |=>
        (res.clocks == STD_REG_LONG_RI))
        else $error("long register base not raised");

endmodule // ict_cycle_timing

// >>> rtl/ict_pkg.sv
package ict_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int CLK_W   = 10;
    localparam int CNT_W   = 4;
    localparam int AC_CW   = 5;
    localparam int AC_RW   = 3;
    localparam int WAIT_W  = 8;
    localparam int DATA_W  = 16;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, COMPARE_OP, EXCLUSIVE_OR_OP,
        SIGNED_DIVIDE, UNSIGNED_DIVIDE, SIGNED_MULTIPLY, UNSIGNED_MULTIPLY
    } ict_op_e;

    typedef enum logic [3:0] {
        MODE_DATA_REGISTER_OPERAND, MODE_ADDRESS_REGISTER_OPERAND,
        MODE_INDIRECT, MODE_POSTINC, MODE_PREDEC, MODE_DISPLACEMENT,
        MODE_INDEXED, MODE_ABS_SHORT, MODE_ABS_LONG, MODE_PC_DISPLACEMENT,
        MODE_PC_INDEXED, MODE_IMMEDIATE
    } ict_mode_e;

    typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} ict_size_e;

    typedef enum logic [1:0] {
        FORM_TO_DATA_REG, FORM_TO_ADDR_REG, FORM_TO_MEMORY
    } ict_form_e;

    typedef struct packed {
        ict_op_e                 op;
        ict_size_e               size;
        ict_form_e               form;
        ict_mode_e               src_mode;
        ict_mode_e               dst_mode;
        logic [DATA_W-1:0]       src_data;
        logic [WAIT_W-1:0]       wait_clocks;
    } ict_req_s;

    typedef struct packed {
        logic [CLK_W-1:0]        clocks;
        logic [CNT_W-1:0]        reads;
        logic [CNT_W-1:0]        writes;
        logic                    illegal;
    } ict_res_s;

    // ****************************************************************
    // Address calculation costs, byte/word size, and the extra for long size
    // ****************************************************************
    localparam logic [AC_CW-1:0] AC_CLK_IND     = 5'h04;
    localparam logic [AC_CW-1:0] AC_CLK_POSTINC = 5'h04;
    localparam logic [AC_CW-1:0] AC_CLK_PREDEC  = 5'h06;
    localparam logic [AC_CW-1:0] AC_CLK_DISP    = 5'h08;
    localparam logic [AC_CW-1:0] AC_CLK_INDEXED = 5'h0a;
    localparam logic [AC_CW-1:0] AC_CLK_ABSW    = 5'h08;
    localparam logic [AC_CW-1:0] AC_CLK_ABSL    = 5'h0c;
    localparam logic [AC_CW-1:0] AC_CLK_PCDISP  = 5'h08;
    localparam logic [AC_CW-1:0] AC_CLK_PCINDEX = 5'h0a;
    localparam logic [AC_CW-1:0] AC_CLK_IMM     = 5'h04;
    localparam logic [AC_RW-1:0] AC_RD_ONE      = 3'h1;
    localparam logic [AC_RW-1:0] AC_RD_TWO      = 3'h2;
    localparam logic [AC_RW-1:0] AC_RD_THREE    = 3'h3;
    localparam logic [AC_CW-1:0] AC_LONG_CLK    = 5'h04;
    localparam logic [AC_RW-1:0] AC_LONG_RD     = 3'h1;

    // ****************************************************************
    // Instruction base costs
    // ****************************************************************
    localparam logic [CLK_W-1:0] BUS_CYCLE_CLK      = 10'h004;
    localparam logic [CLK_W-1:0] MOVE_BASE_CLK      = 10'h004;
    localparam logic [CLK_W-1:0] MOVE_LONG_DST_CLK  = 10'h004;
    localparam logic [CNT_W-1:0] BASE_RD            = 4'h1;
    localparam logic [CNT_W-1:0] WR_BYTE_WORD       = 4'h1;
    localparam logic [CNT_W-1:0] WR_LONG            = 4'h2;
    localparam logic [CLK_W-1:0] STD_REG_BW_CLK     = 10'h004;
    localparam logic [CLK_W-1:0] STD_REG_LONG_CLK   = 10'h006;
    localparam logic [CLK_W-1:0] STD_REG_LONG_RI    = 10'h008;
    localparam logic [CLK_W-1:0] ADD_AREG_BW_CLK    = 10'h008;
    localparam logic [CLK_W-1:0] CMP_AREG_CLK       = 10'h006;
    localparam logic [CLK_W-1:0] CMP_LONG_CLK       = 10'h006;
    localparam logic [CLK_W-1:0] XOR_REG_LONG_CLK   = 10'h008;
    localparam logic [CLK_W-1:0] STD_MEM_BW_CLK     = 10'h008;
    localparam logic [CLK_W-1:0] STD_MEM_LONG_CLK   = 10'h00c;
    localparam logic [CLK_W-1:0] SDIV_MAX_CLK       = 10'h09e;
    localparam logic [CLK_W-1:0] UDIV_MAX_CLK       = 10'h08c;
    localparam logic [CLK_W-1:0] MUL_BASE_CLK       = 10'h026;
    localparam logic [CLK_W-1:0] MUL_MAX_CLK        = 10'h046;

    // Reference points used by the checks
    localparam logic [CLK_W-1:0] MOVE_BYTE_WORST_CLK = 10'h01c;
    localparam logic [CNT_W-1:0] MOVE_BYTE_WORST_RD  = 4'h6;
    localparam logic [CLK_W-1:0] MOVE_REG_IND_L_CLK  = 10'h00c;
    localparam logic [CLK_W-1:0] MOVE_LONG_WORST_CLK = 10'h024;
    localparam logic [CNT_W-1:0] MOVE_LONG_WORST_RD  = 4'h7;

endpackage
